/* hdl/mptb_time_base.sv */
// Purpose: Motor PWM time base with prescaler, postscaler, buffered period
// Assumes: Plain register port, reads answered one cycle later
// Notes:   Counter clock is the instruction clock i_ref_clk (oscillator/4)
`timescale 1ns/1ns
module mptb_time_base
	import mptb_pkg::*;
(
	input  wire logic                   i_ref_clk,
	input  wire logic                   i_rstn,
	input  wire logic [MPTB_AW-1:0]     i_addr,
	input  wire logic [MPTB_DW-1:0]     i_wdata,
	input  wire logic                   i_wr,
	input  wire logic                   i_rd,
	input  wire logic                   i_high_side_drive,
	output logic      [MPTB_DW-1:0]     o_rdata,
	output logic                        o_event,
	output logic      [MPTB_CW-1:0]     o_time_base_counter,
	output logic                        o_count_direction_flag,
	output logic                        o_high_side_output,
	output logic                        o_low_side_output
);
	logic                    time_base_enable;
	mptb_mode_e              time_base_mode_select;
	logic [3:0]              postscale_select;
	logic [1:0]              prescale_select;
	logic [MPTB_CW-1:0]      cnt;
	logic                    dir;
	logic [MPTB_CW-1:0]      period_register;
	logic [MPTB_CW-1:0]      period_buffer;
	logic [3:0]              post_cnt;
	logic                    comp_en;
	logic                    hs_meta;
	logic                    hs_sync;
	logic                    tick;
	logic                    wr_ctrl;
	logic                    wr_cnt;
	logic                    wr_per;
	logic                    running;
	logic                    at_match;
	logic                    at_zero;
	logic                    ev_raw;
	logic                    ev_scaled;
	logic                    scaled_mode;

	// Elaboration check: the counter logic serves a 15-bit width only
	if (MPTB_CW != 15) begin : g_cw_check
		$error("Counter width must be 15");
	end

	// Write decode
	assign wr_ctrl = i_wr && (i_addr == MPTB_ADR_CTRL);
	assign wr_cnt  = i_wr && (i_addr == MPTB_ADR_CNT);
	assign wr_per  = i_wr && (i_addr == MPTB_ADR_PER);

	// Prescaler clears on counter or control writes
	mptb_prescale u_pre (
		.i_ref_clk (i_ref_clk),
		.i_rstn    (i_rstn),
		.i_clr     (wr_ctrl || wr_cnt),
		.i_sel     (prescale_select),
		.o_tick    (tick)
	);

	// Count conditions; zero period freezes counter, direction and events
	assign running  = time_base_enable && (period_register != 15'h0000);
	assign at_match = (cnt == period_register);
	assign at_zero  = (cnt == 15'h0000);

	// Raw event per mode, only on an actual count step
	always_comb begin
		ev_raw      = 1'b0;
		scaled_mode = 1'b0;
		if (running && tick && !wr_cnt) begin
			case (time_base_mode_select)
				MPTB_FREE: begin
					ev_raw      = at_match;
					scaled_mode = 1'b1;
				end
				MPTB_SHOT: ev_raw = at_match;
				MPTB_UPDN: begin
					ev_raw      = at_zero && dir;
					scaled_mode = 1'b1;
				end
				MPTB_DBL: ev_raw = (at_zero && dir) || (at_match && !dir);
				default: ev_raw = 1'b0;
			endcase
		end
	end

	assign ev_scaled = ev_raw && (!scaled_mode || (post_cnt == postscale_select));

	// Control register, enable self-clears in single-shot
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			time_base_enable      <= 1'b0;
			time_base_mode_select <= MPTB_FREE;
			postscale_select      <= 4'h0;
			prescale_select       <= 2'h0;
		end else if (wr_ctrl) begin
			time_base_enable      <= i_wdata[MPTB_EN_BIT];
			time_base_mode_select <= mptb_mode_e'(i_wdata[MPTB_MOD_LSB +: 2]);
			postscale_select      <= i_wdata[MPTB_OPS_LSB +: 4];
			prescale_select       <= i_wdata[MPTB_CKPS_LSB +: 2];
		end else if (running && tick && !wr_cnt && at_match && time_base_mode_select == MPTB_SHOT) begin
			time_base_enable <= 1'b0;
		end
	end

	// Counter and direction; up/down holds each turning value for one step
	// so that the full period is twice the single-direction count
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt <= 15'h0000;
			dir <= 1'b0;
		end else if (wr_cnt) begin
			cnt <= i_wdata[MPTB_CW-1:0];
		end else if (running && tick) begin
			if (time_base_mode_select == MPTB_FREE || time_base_mode_select == MPTB_SHOT) begin
				dir <= 1'b0;
				cnt <= at_match ? 15'h0000 : cnt + 15'h0001;
			end else if (!dir) begin
				if (at_match) begin
					dir <= 1'b1;
				end else begin
					cnt <= cnt + 15'h0001;
				end
			end else if (at_zero) begin
				dir <= 1'b0;
			end else begin
				cnt <= cnt - 15'h0001;
			end
		end
	end

	// Postscaler counter
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn)
			post_cnt <= 4'h0;
		else if (wr_ctrl || wr_cnt)
			post_cnt <= 4'h0;
		else if (ev_raw && scaled_mode)
			post_cnt <= (post_cnt == postscale_select) ? 4'h0 : post_cnt + 4'h1;
	end

	// Period buffer and active period
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			period_buffer   <= MPTB_PER_RST;
			period_register <= MPTB_PER_RST;
		end else begin
			if (wr_per)
				period_buffer <= i_wdata[MPTB_CW-1:0];
			if (!time_base_enable)
				period_register <= period_buffer;
			else if (running && tick && !wr_cnt) begin
				if ((time_base_mode_select == MPTB_FREE || time_base_mode_select == MPTB_SHOT) && at_match)
					period_register <= period_buffer;
				else if (time_base_mode_select[1] && at_zero)
					period_register <= period_buffer;
			end
		end
	end

	// Output control register
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn)
			comp_en <= 1'b1;
		else if (i_wr && i_addr == MPTB_ADR_OUT)
			comp_en <= i_wdata[MPTB_CMP_BIT];
	end

	// High-side drive synchroniser
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			hs_meta <= 1'b0;
			hs_sync <= 1'b0;
		end else begin
			hs_meta <= i_high_side_drive;
			hs_sync <= hs_meta;
		end
	end

	// Registered outputs
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_event                <= 1'b0;
			o_time_base_counter    <= 15'h0000;
			o_count_direction_flag <= 1'b0;
			o_high_side_output     <= 1'b0;
			o_low_side_output      <= 1'b0;
		end else begin
			o_event                <= ev_scaled;
			o_time_base_counter    <= cnt;
			o_count_direction_flag <= dir;
			o_high_side_output     <= hs_sync;
			o_low_side_output      <= comp_en ? !hs_sync : 1'b0;
		end
	end

	// Read data, valid the cycle after the strobe
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn)
			o_rdata <= 16'h0000;
		else if (i_rd) begin
			case (i_addr)
				MPTB_ADR_CTRL: o_rdata <= {time_base_enable, 7'h00, postscale_select,
					prescale_select, time_base_mode_select};
				MPTB_ADR_CNT:  o_rdata <= {dir, cnt};
				MPTB_ADR_PER:  o_rdata <= {1'b0, period_buffer};
				MPTB_ADR_OUT:  o_rdata <= {15'h0000, comp_en};
				default:       o_rdata <= 16'h0000;
			endcase
		end else
			o_rdata <= 16'h0000;
	end

	// Single-shot clears its own enable one cycle after the match step
	property p_shot_clear;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(running && tick && !i_wr && at_match && time_base_mode_select == MPTB_SHOT)
			|=> (!time_base_enable && cnt == 15'h0000);
	endproperty
	a_shot_clear: assert property (p_shot_clear) else $error("single-shot did not halt");

	// Zero period freezes the counter
	property p_zero_stop;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(period_register == 15'h0000 && !i_wr) |=> $stable(cnt);
	endproperty
	a_zero_stop: assert property (p_zero_stop) else $error("counter moved with zero period");

	// Disabled counter holds its value
	property p_hold;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(!time_base_enable && !i_wr) |=> $stable(cnt);
	endproperty
	a_hold: assert property (p_hold) else $error("counter moved while disabled");

	// Up/down turns at match
	property p_turn;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(running && tick && !i_wr && time_base_mode_select[1] && !dir && at_match)
			|=> (dir && $stable(cnt));
	endproperty
	a_turn: assert property (p_turn) else $error("no reversal at match");

	// Low side complements high side once the enable has stood two cycles
	property p_comp;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		comp_en ##1 comp_en |=> (o_low_side_output != o_high_side_output);
	endproperty
	a_comp: assert property (p_comp) else $error("outputs not complementary");

	// Up/down holds zero for one step while turning upward
	property p_bottom;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(running && tick && !i_wr && time_base_mode_select[1] && dir && at_zero)
			|=> (!dir && cnt == 15'h0000);
	endproperty
	a_bottom: assert property (p_bottom) else $error("no upward turn at zero");

	// Free mode wraps to zero after a match and keeps running
	property p_free_wrap;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(running && tick && !i_wr && at_match && time_base_mode_select == MPTB_FREE)
			|=> (cnt == 15'h0000 && time_base_enable);
	endproperty
	a_free_wrap: assert property (p_free_wrap) else $error("free mode did not wrap");

	// Free and single-shot modes only count upward
	property p_up_only;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(running && tick && !i_wr && !time_base_mode_select[1]) |=> !dir;
	endproperty
	a_up_only: assert property (p_up_only) else $error("edge mode counted down");

	// Disabled time base copies the buffered period
	property p_idle_reload;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(!time_base_enable && !i_wr) |=> (period_register == $past(period_buffer));
	endproperty
	a_idle_reload: assert property (p_idle_reload) else $error("no reload while disabled");

	// Edge modes take the buffered period at the match step
	property p_match_load;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(running && tick && !i_wr && !time_base_mode_select[1] && at_match)
			|=> (period_register == $past(period_buffer));
	endproperty
	a_match_load: assert property (p_match_load) else $error("no reload at match");

	// Single-shot match gives an event in the next cycle
	property p_shot_event;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(running && tick && !i_wr && at_match && time_base_mode_select == MPTB_SHOT) |=> o_event;
	endproperty
	a_shot_event: assert property (p_shot_event) else $error("single-shot event missing");

	// Double-update match while counting up gives an unscaled event
	property p_dbl_event;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(running && tick && !i_wr && at_match && !dir && time_base_mode_select == MPTB_DBL)
			|=> o_event;
	endproperty
	a_dbl_event: assert property (p_dbl_event) else $error("double-update event missing");

	// Zero period never raises an event
	property p_zero_quiet;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(period_register == 15'h0000) |=> !o_event;
	endproperty
	a_zero_quiet: assert property (p_zero_quiet) else $error("event with zero period");

	// Counter or control write clears the postscaler
	property p_post_clear;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(i_wr && (i_addr == MPTB_ADR_CTRL || i_addr == MPTB_ADR_CNT)) |=> (post_cnt == 4'h0);
	endproperty
	a_post_clear: assert property (p_post_clear) else $error("postscaler not cleared");

	// Control write alone leaves the counter untouched
	property p_ctrl_keep;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(wr_ctrl && !(running && tick)) |=> $stable(cnt);
	endproperty
	a_ctrl_keep: assert property (p_ctrl_keep) else $error("control write moved counter");
endmodule // mptb_time_base

/* hdl/mptb_pkg.sv */
// Purpose: Shared constants for the motor PWM time base
// Assumes: 16-bit register port, 10 MHz instruction clock
// Notes:   Register indices are word addresses on the plain port
package mptb_pkg;
	localparam int MPTB_AW            = 2;
	localparam int MPTB_DW            = 16;
	localparam int MPTB_CW            = 15;
	// Register addresses
	localparam logic [1:0] MPTB_ADR_CTRL = 2'h0;
	localparam logic [1:0] MPTB_ADR_CNT  = 2'h1;
	localparam logic [1:0] MPTB_ADR_PER  = 2'h2;
	localparam logic [1:0] MPTB_ADR_OUT  = 2'h3;
	// Control, counter and output register fields
	localparam int MPTB_EN_BIT        = 15;
	localparam int MPTB_OPS_LSB       = 4;
	localparam int MPTB_CKPS_LSB      = 2;
	localparam int MPTB_MOD_LSB       = 0;
	localparam int MPTB_DIR_BIT       = 15;
	localparam int MPTB_CMP_BIT       = 0;
	localparam int MPTB_POL_BIT       = 1;
	// Reset values
	localparam logic [14:0] MPTB_PER_RST = 15'h0000;
	// Mode encodings
	typedef enum logic [1:0] {
		MPTB_FREE = 2'h0,
		MPTB_SHOT = 2'h1,
		MPTB_UPDN = 2'h2,
		MPTB_DBL  = 2'h3
	} mptb_mode_e;
	// Prescale terminal counts for the ratios 1, 4, 16, 64
	localparam logic [5:0] MPTB_PRE_1  = 6'h00;
	localparam logic [5:0] MPTB_PRE_4  = 6'h03;
	localparam logic [5:0] MPTB_PRE_16 = 6'h0F;
	localparam logic [5:0] MPTB_PRE_64 = 6'h3F;
endpackage

/* hdl/mptb_prescale.sv */
// Purpose: Input-clock prescaler giving a one-cycle count enable
// Assumes: Same clock as the time base
// Notes:   Synchronous clear restarts the division
`timescale 1ns/1ns
module mptb_prescale
	import mptb_pkg::*;
(
	input  wire logic       i_ref_clk,
	input  wire logic       i_rstn,
	input  wire logic       i_clr,
	input  wire logic [1:0] i_sel,
	output logic            o_tick
);
	logic [5:0] cnt;
	logic [5:0] lim;

	// Terminal count per ratio
	always_comb begin
		case (i_sel)
			2'h0: lim = MPTB_PRE_1;
			2'h1: lim = MPTB_PRE_4;
			2'h2: lim = MPTB_PRE_16;
			default: lim = MPTB_PRE_64;
		endcase
	end

	// Divider counter, cleared on request
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt    <= 6'h00;
			o_tick <= 1'b0;
		end else if (i_clr) begin
			cnt    <= 6'h00;
			o_tick <= 1'b0;
		end else if (cnt >= lim) begin
			cnt    <= 6'h00;
			o_tick <= 1'b1;
		end else begin
			cnt    <= cnt + 6'h01;
			o_tick <= 1'b0;
		end
	end
endmodule // mptb_prescale

/* verif/motor_pwm_time_base_test.sv */
// Purpose: Self-checking bench for the motor PWM time base
// Assumes: Read data stands in the cycle after the read strobe
// Notes:   Observers sample on the falling edge, away from bench drives
`timescale 1ns/1ns
module motor_pwm_time_base_test;
	import mptb_pkg::*;
	logic               i_ref_clk         = 1'b0;
	logic               i_rstn            = 1'b0;
	logic [MPTB_AW-1:0] i_addr            = '0;
	logic [MPTB_DW-1:0] i_wdata           = '0;
	logic               i_wr              = 1'b0;
	logic               i_rd              = 1'b0;
	logic               i_high_side_drive = 1'b0;
	logic [MPTB_DW-1:0] o_rdata;
	logic               o_event;
	logic [MPTB_CW-1:0] o_time_base_counter;
	logic               o_count_direction_flag;
	logic               o_high_side_output;
	logic               o_low_side_output;
	logic [15:0]        rq[$];
	logic [15:0]        lfsr              = 16'h3C85;
	logic [15:0]        v;
	logic               rd_q              = 1'b0;
	logic               pair_on           = 1'b1;
	int                 n_mismatch        = 0;
	int                 checked           = 0;
	int                 ev_cnt            = 0;
	int                 dir_n             = 0;
	int                 cmax              = 0;
	int                 cyc               = 0;

	mptb_time_base i_dut (
		.i_ref_clk              (i_ref_clk),
		.i_rstn                 (i_rstn),
		.i_addr                 (i_addr),
		.i_wdata                (i_wdata),
		.i_wr                   (i_wr),
		.i_rd                   (i_rd),
		.i_high_side_drive      (i_high_side_drive),
		.o_rdata                (o_rdata),
		.o_event                (o_event),
		.o_time_base_counter    (o_time_base_counter),
		.o_count_direction_flag (o_count_direction_flag),
		.o_high_side_output     (o_high_side_output),
		.o_low_side_output      (o_low_side_output)
	);

	// 10 MHz clock
	always #50 i_ref_clk = ~i_ref_clk;

	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// One-cycle write; strobe dropped a cycle before any next request
	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge i_ref_clk);
		i_addr  <= a;
		i_wdata <= d;
		i_wr    <= 1'b1;
		@(posedge i_ref_clk);
		i_wr    <= 1'b0;
	endtask

	// One-cycle read; expected word queued for the observer
	task automatic rd(input logic [1:0] a, input logic [15:0] e);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_rd   <= 1'b1;
		rq.push_back(e);
		@(posedge i_ref_clk);
		i_rd   <= 1'b0;
	endtask

	// Count events over a steady window after a settling time
	task automatic win(input string nm, input int settle, input int n, input int e);
		repeat (settle) @(posedge i_ref_clk);
		ev_cnt = 0;
		dir_n  = 0;
		cmax   = 0;
		repeat (n) @(posedge i_ref_clk);
		chk(nm, 16'(e), 16'(ev_cnt));
		$display("done %s", nm);
	endtask

	// Random high-side drive and hang guard
	always @(posedge i_ref_clk) begin
		cyc++;
		lfsr              <= lfsr_next(lfsr);
		i_high_side_drive <= lfsr[0];
		rd_q              <= i_rd;
		if (cyc == 6000) begin
			n_mismatch++;
			test_done();
		end
	end

	// Observers: read data, events, direction, counter peak, output pair
	always @(negedge i_ref_clk) begin
		if (rd_q) begin
			if (rq.size() == 0)
				chk("read queue", 16'h0001, 16'h0000);
			else
				chk("read data", rq.pop_front(), o_rdata);
		end
		if (o_event === 1'b1)
			ev_cnt++;
		if (o_count_direction_flag === 1'b1)
			dir_n++;
		if (int'(o_time_base_counter) > cmax)
			cmax = int'(o_time_base_counter);
		if (cyc > 8 && pair_on)
			chk("low side", {15'h0000, ~o_high_side_output}, {15'h0000, o_low_side_output});
	end

	// Main sequence
	initial begin
		repeat (4) @(posedge i_ref_clk);
		i_rstn <= 1'b1;
		rd(MPTB_ADR_CTRL, 16'h0000);
		rd(MPTB_ADR_CNT, 16'h0000);
		rd(MPTB_ADR_PER, 16'h0000);
		wr(MPTB_ADR_CTRL, 16'h8000);
		win("zero period", 4, 40, 0);
		rd(MPTB_ADR_CNT, 16'h0000);
		// Zero period only changes through a disabled time base
		wr(MPTB_ADR_CTRL, 16'h0000);
		wr(MPTB_ADR_PER, 16'h0003);
		for (int s = 0; s < 4; s++) begin
			wr(MPTB_ADR_CTRL, 16'h8000 | 16'(s << 2));
			win("prescale", 4 << (2 * s), 16 << (2 * s), 4);
			chk("count peak", 16'h0003, 16'(cmax));
		end
		wr(MPTB_ADR_CTRL, 16'h8020);
		win("postscale", 12, 48, 4);
		wr(MPTB_ADR_CTRL, 16'h8002);
		win("up down", 12, 64, 8);
		chk("down share", 16'h0020, 16'(dir_n));
		wr(MPTB_ADR_CTRL, 16'h8012);
		win("up down postscale", 12, 64, 4);
		wr(MPTB_ADR_CTRL, 16'h8033);
		win("double update", 12, 64, 16);
		wr(MPTB_ADR_CTRL, 16'h0000);
		wr(MPTB_ADR_CNT, 16'h0000);
		wr(MPTB_ADR_PER, 16'h0005);
		wr(MPTB_ADR_CTRL, 16'h8031);
		win("single shot", 0, 40, 1);
		rd(MPTB_ADR_CTRL, 16'h0031);
		rd(MPTB_ADR_CNT, 16'h0000);
		// Random counter values survive a control write while stopped
		repeat (3) begin
			v = lfsr;
			wr(MPTB_ADR_CNT, v);
			rd(MPTB_ADR_CNT, {1'b0, v[14:0]});
			wr(MPTB_ADR_CTRL, 16'h00F3);
			rd(MPTB_ADR_CNT, {1'b0, v[14:0]});
		end
		wr(MPTB_ADR_CNT, 16'h0000);
		wr(MPTB_ADR_PER, 16'h0007);
		rd(MPTB_ADR_PER, 16'h0007);
		wr(MPTB_ADR_CTRL, 16'h8000);
		win("disabled reload", 8, 80, 10);
		wr(MPTB_ADR_PER, 16'h0004);
		win("buffered period", 16, 50, 10);
		wr(MPTB_ADR_PER, 16'h0000);
		win("period to zero", 16, 50, 0);
		wr(MPTB_ADR_CTRL, 16'h0000);
		// Complementary pair switched off, low side held low, then restored
		rd(MPTB_ADR_OUT, 16'h0001);
		pair_on = 1'b0;
		wr(MPTB_ADR_OUT, 16'h0000);
		rd(MPTB_ADR_OUT, 16'h0000);
		repeat (4) begin
			@(negedge i_ref_clk);
			chk("low side off", 16'h0000, {15'h0000, o_low_side_output});
		end
		wr(MPTB_ADR_OUT, 16'h0001);
		repeat (3) @(posedge i_ref_clk);
		pair_on = 1'b1;
		$display("done pair control");
		repeat (4) @(posedge i_ref_clk);
		test_done();
	end
endmodule // motor_pwm_time_base_test
